// >>> hdl/urx_receiver.sv
// Asynchronous serial receiver with two-entry buffer and APB registers
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module urx_receiver
   import urx_pkg::*;
#(
   parameter int BAUD_WIDTH = 12
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic global_irq_enable,
   input wire logic serial_rx_pin,
   output logic rx_pin_override,
   output logic rx_complete_irq
);
   typedef enum logic [1:0] {
      URX_IDLE = 2'b00,
      URX_START = 2'b01,
      URX_BITS = 2'b10,
      URX_HOLD = 2'b11
   } urx_state_type;

   urx_state_type state;
   urx_state_type next_state;
   logic [7:0] control;
   logic [7:0] next_control;
   logic [7:0] format;
   logic [7:0] next_format;
   logic double_speed_select;
   logic next_double_speed_select;
   logic [BAUD_WIDTH-1:0] baud;
   logic [BAUD_WIDTH-1:0] next_baud;
   logic [BAUD_WIDTH-1:0] prescale;
   logic [BAUD_WIDTH-1:0] next_prescale;
   logic [4:0] phase;
   logic [4:0] next_phase;
   logic [3:0] bit_index;
   logic [3:0] next_bit_index;
   logic [2:0] votes;
   logic [2:0] next_votes;
   logic [9:0] shifter;
   logic [9:0] next_shifter;
   logic [11:0] pending;
   logic [11:0] next_pending;
   logic overrun_flag;
   logic next_overrun_flag;
   logic line_prev;
   logic next_line_prev;
   logic [31:0] next_prdata;

   logic tick;
   logic rx_enable;
   logic [4:0] osr;
   logic [4:0] vote_first;
   logic [3:0] data_bits;
   logic [3:0] frame_bits;
   logic parity_on;
   logic bit_level;
   logic push;
   logic pop;
   logic fifo_full;
   logic rx_complete_flag;
   logic [11:0] head;
   logic [11:0] entry;
   logic acc;
   logic wr;
   logic parity_bad;
   logic [8:0] data_mask;
   logic vote_window;
   logic vote_done;
   logic bit_last;
   logic stop_bit;

   // Entry layout: [8:0] data, 9 frame error, 10 overrun, 11 parity error
   assign rx_enable = control[URX_EN_BIT];
   assign parity_on = format[URX_PM1_BIT];
   assign osr = double_speed_select ? URX_OSR_DOUBLE : URX_OSR_NORMAL;
   assign vote_first = double_speed_select ? 5'h04 : 5'h08;
   assign data_bits = (format[URX_SIZE_LSB+:3] == URX_SIZE_NINE) ? 4'h9 :
      4'h5 + {2'h0, format[URX_SIZE_LSB+:2]};
   assign frame_bits = data_bits + {3'h0, parity_on};
   assign tick = prescale == '0;
   // Phase equals the number of the sample taken at this tick
   assign vote_window = phase >= vote_first && phase <= vote_first + 5'h02;
   assign vote_done = phase == vote_first + 5'h03;
   assign bit_last = phase == osr;
   assign stop_bit = bit_index == frame_bits;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign pop = acc && !pwrite && paddr == URX_DATA_OFS;
   assign pready = 1'b1;
   assign rx_pin_override = rx_enable;
   // Level request, held until the buffer is read empty
   assign rx_complete_irq = rx_complete_flag && control[URX_IE_BIT] &&
      global_irq_enable;

   urx_vote u_vote (
      .samples(votes),
      .level(bit_level)
   );

   // Clearing enable empties the buffer at the next edge
   urx_fifo #(.WIDTH(12), .DEPTH(2)) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .ce(ce),
      .flush(!rx_enable),
      .push(push),
      .push_data(pending),
      .pop(pop),
      .head(head),
      .not_empty(rx_complete_flag),
      .full(fifo_full)
   );

   always_comb begin
      data_mask = 9'h1ff >> (4'h9 - data_bits);
      parity_bad = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(data_bits)) begin
            parity_bad = parity_bad ^ shifter[i];
         end
      end
      // Even: data xor parity must be zero; odd: one
      parity_bad = parity_on && (parity_bad ^ shifter[data_bits] ^
         format[URX_PM0_BIT]);
      entry = {parity_bad, overrun_flag, !bit_level, shifter[8:0] & data_mask};
   end

   always_comb begin
      next_state = state;
      next_prescale = tick ? baud : prescale - 1'b1;
      next_phase = phase;
      next_bit_index = bit_index;
      next_votes = votes;
      next_shifter = shifter;
      next_pending = pending;
      next_overrun_flag = overrun_flag;
      next_line_prev = serial_rx_pin;
      push = 1'b0;
      // A held frame moves in as soon as a buffer slot frees
      if (state == URX_HOLD && (!fifo_full || pop)) begin
         push = 1'b1;
         next_overrun_flag = 1'b0;
         next_state = URX_IDLE;
      end
      if (!rx_enable) begin
         next_state = URX_IDLE;
         next_overrun_flag = 1'b0;
      end else if (tick) begin
         unique case (state)
            URX_IDLE, URX_HOLD: begin
               if (line_prev && !serial_rx_pin) begin
                  // Edge sample is sample one, so the next tick takes sample two
                  next_phase = 5'h02;
                  next_state = URX_START;
                  if (state == URX_HOLD && !push) begin
                     // The held frame is overwritten; the new one carries the overrun
                     next_overrun_flag = 1'b1;
                  end
               end
            end
            URX_START, URX_BITS: begin
               next_phase = phase + 1'b1;
               if (vote_window) begin
                  next_votes = {votes[1:0], serial_rx_pin};
               end
               if (state == URX_START && vote_done) begin
                  if (bit_level) begin
                     next_state = URX_IDLE;
                  end
               end
               if (bit_last) begin
                  next_phase = 5'h01;
                  if (state == URX_START) begin
                     next_state = URX_BITS;
                     next_bit_index = 4'h0;
                  end
               end
               if (state == URX_BITS && vote_done) begin
                  if (stop_bit) begin
                     // First stop bit ends the frame; later stop bits ignored
                     next_pending = entry;
                     next_state = URX_HOLD;
                     next_line_prev = 1'b0;
                  end else begin
                     next_shifter[bit_index] = bit_level;
                     next_bit_index = bit_index + 1'b1;
                  end
               end
            end
         endcase
      end else begin
         next_line_prev = line_prev;
      end
   end

   always_comb begin
      next_control = control;
      next_format = format;
      next_double_speed_select = double_speed_select;
      next_baud = baud;
      next_prdata = 32'h0;
      if (wr) begin
         unique case (paddr)
            // Error flags are not writable from software
            URX_STATUS_OFS: next_double_speed_select = pwdata[URX_DS_BIT];
            URX_CONTROL_OFS: next_control = pwdata[7:0] & 8'h90;
            URX_FORMAT_OFS: next_format = pwdata[7:0];
            URX_BAUD_OFS: next_baud = pwdata[BAUD_WIDTH-1:0];
            default: ;
         endcase
      end
      if (acc && !pwrite) begin
         unique case (paddr)
            URX_STATUS_OFS: begin
               // Error flags hide while the buffer is empty
               next_prdata[URX_RXC_BIT] = rx_complete_flag;
               next_prdata[URX_FE_BIT] = rx_complete_flag & head[9];
               next_prdata[URX_DOR_BIT] = rx_complete_flag & head[10];
               next_prdata[URX_PE_BIT] = rx_complete_flag & head[11];
               next_prdata[URX_DS_BIT] = double_speed_select;
            end
            URX_CONTROL_OFS: next_prdata[7:0] = control | {6'h0, head[8], 1'b0};
            URX_FORMAT_OFS: next_prdata[7:0] = format;
            URX_DATA_OFS: next_prdata[7:0] = head[7:0];
            URX_BAUD_OFS: next_prdata[BAUD_WIDTH-1:0] = baud;
            default: ;
         endcase
      end
   end

   // Read data is combinational off head to match zero-wait pready
   assign prdata = next_prdata;
   assign pslverr = 1'b0;

   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= URX_IDLE;
         control <= 8'h00;
         format <= URX_FORMAT_RST;
         double_speed_select <= 1'b0;
         baud <= URX_BAUD_RST;
         prescale <= '0;
         phase <= 5'h00;
         bit_index <= 4'h0;
         votes <= 3'h7;
         shifter <= 10'h000;
         pending <= 12'h000;
         overrun_flag <= 1'b0;
         line_prev <= 1'b1;
      end else if (ce) begin
         state <= next_state;
         control <= next_control;
         format <= next_format;
         double_speed_select <= next_double_speed_select;
         baud <= next_baud;
         prescale <= next_prescale;
         phase <= next_phase;
         bit_index <= next_bit_index;
         votes <= next_votes;
         shifter <= next_shifter;
         pending <= next_pending;
         overrun_flag <= next_overrun_flag;
         line_prev <= next_line_prev;
      end
   end
endmodule : urx_receiver

// >>> hdl/urx_pkg.sv
// Package of register map, field positions and frame constants for the serial receiver
package urx_pkg;
   // Register byte offsets
   localparam logic [7:0] URX_STATUS_OFS = 8'h00;
   localparam logic [7:0] URX_CONTROL_OFS = 8'h04;
   localparam logic [7:0] URX_FORMAT_OFS = 8'h08;
   localparam logic [7:0] URX_DATA_OFS = 8'h0c;
   localparam logic [7:0] URX_BAUD_OFS = 8'h10;
   // Status register fields
   localparam int URX_PE_BIT = 2;
   localparam int URX_DOR_BIT = 3;
   localparam int URX_FE_BIT = 4;
   localparam int URX_DS_BIT = 1;
   localparam int URX_RXC_BIT = 7;
   // Control register fields
   localparam int URX_B8_BIT = 1;
   localparam int URX_EN_BIT = 4;
   localparam int URX_IE_BIT = 7;
   // Format register fields
   localparam int URX_SIZE_LSB = 1;
   localparam int URX_SB_BIT = 6;
   localparam int URX_PM0_BIT = 4;
   localparam int URX_PM1_BIT = 5;
   // Reset values
   localparam logic [7:0] URX_FORMAT_RST = 8'h06;
   localparam logic [11:0] URX_BAUD_RST = 12'h000;
   // Sampling and character size
   localparam logic [4:0] URX_OSR_NORMAL = 5'h10;
   localparam logic [4:0] URX_OSR_DOUBLE = 5'h08;
   localparam logic [2:0] URX_SIZE_NINE = 3'h7;
endpackage : urx_pkg

// >>> hdl/urx_vote.sv
// Three-sample majority vote
`timescale 1ns/1ps
module urx_vote
   import urx_pkg::*;
(
   input wire logic [2:0] samples,
   output logic level
);
   assign level = (samples[0] & samples[1]) | (samples[1] & samples[2]) |
      (samples[0] & samples[2]);
endmodule : urx_vote

// >>> hdl/urx_fifo.sv
// Two-entry receive buffer holding data and per-frame error flags
`timescale 1ns/1ps
module urx_fifo
   import urx_pkg::*;
#(
   parameter int WIDTH = 12,
   parameter int DEPTH = 2
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic flush,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head,
   output logic not_empty,
   output logic full
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [1:0] count;
   logic [1:0] next_count;
   logic do_pop;
   logic do_push;

   assign head = mem[0];
   assign not_empty = count != 2'h0;
   assign full = count == 2'(DEPTH);
   assign do_pop = pop && not_empty;
   assign do_push = push && (!full || do_pop);

   always_comb begin
      next_count = count;
      for (int i = 0; i < DEPTH; i++) begin
         next_mem[i] = mem[i];
      end
      if (flush) begin
         next_count = 2'h0;
      end else begin
         if (do_pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
               next_mem[i] = mem[i + 1];
            end
         end
         if (do_push) begin
            next_mem[int'(count) - (do_pop ? 1 : 0)] = push_data;
         end
         next_count = count + 2'(do_push) - 2'(do_pop);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         count <= 2'h0;
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else if (ce) begin
         count <= next_count;
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= next_mem[i];
         end
      end
   end
endmodule : urx_fifo

// >>> test/urx_receiver_asserts.sv
// Port checker for the serial receiver
`timescale 1ns/1ps
module urx_chk
   import urx_pkg::*;
#(
   parameter int BAUD_WIDTH = 12
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic global_irq_enable,
   input wire logic serial_rx_pin,
   input wire logic rx_pin_override,
   input wire logic rx_complete_irq
);
   wire wr_ctl = psel && penable && pwrite && ce && paddr == URX_CONTROL_OFS;
   wire rd_sts = psel && penable && !pwrite && paddr == URX_STATUS_OFS;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   a_zero_wait: assert property (psel && penable |-> pready && !pslverr)
      else $error("access not answered at once");
   a_irq_gate: assert property (rx_complete_irq |-> global_irq_enable)
      else $error("interrupt without global enable");
   a_ie_gates_irq: assert property (wr_ctl && !pwdata[URX_IE_BIT] |=> !rx_complete_irq)
      else $error("interrupt after enable cleared");
   a_disable_now: assert property (wr_ctl && !pwdata[URX_EN_BIT] |=> !rx_pin_override)
      else $error("pin still taken after disable");
   a_enable_pin: assert property (wr_ctl && pwdata[URX_EN_BIT] |=> rx_pin_override)
      else $error("pin not taken after enable");
   a_flush_irq: assert property (wr_ctl && !pwdata[URX_EN_BIT] |=> !rx_complete_irq [*4])
      else $error("interrupt survives flush");
   a_no_err_irq: assert property (rd_sts && !prdata[URX_RXC_BIT] |-> !rx_complete_irq)
      else $error("interrupt with empty buffer");
   a_empty_clean: assert property (rd_sts && !prdata[URX_RXC_BIT] |-> prdata[4:2] == 3'h0)
      else $error("error flags with empty buffer");
   a_unmapped_zero: assert property (psel && penable && !pwrite && paddr > URX_BAUD_OFS
      |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   c_frame_err: cover property (rd_sts && prdata[URX_FE_BIT]);
   c_overrun: cover property (rd_sts && prdata[URX_DOR_BIT]);
   c_irq: cover property (rx_complete_irq);
endmodule : urx_chk

bind urx_receiver urx_chk #(.BAUD_WIDTH(BAUD_WIDTH)) i_chk (.mclk(mclk), .reset(reset),
   .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .global_irq_enable(global_irq_enable), .serial_rx_pin(serial_rx_pin),
   .rx_pin_override(rx_pin_override), .rx_complete_irq(rx_complete_irq));

// >>> test/urx_serial_src.sv
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
module urx_serial_src (
   input wire logic mclk,
   output logic line
);
   initial line = 1'b1;
   // Start, data LSB first, parity if par >= 0, one stop of level stp
   task automatic send(input logic [8:0] d, input int nb, input int par, input logic stp,
                       input int per);
      logic b;
      @(posedge mclk);
      for (int k = -1; k <= nb + 1; k++) begin
         if (k == nb && par < 0) continue;
         b = (k < 0) ? 1'b0 : (k < nb) ? d[k] : (k == nb) ? par[0] : stp;
         line <= b;
         repeat (per) @(posedge mclk);
      end
      line <= 1'b1;
   endtask : send
   task automatic spike(input int n);
      @(posedge mclk);
      line <= 1'b0;
      repeat (n) @(posedge mclk);
      line <= 1'b1;
   endtask : spike
endmodule : urx_serial_src

// >>> test/tb_top.sv
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
module tb_top
   import urx_pkg::*;
;
   localparam int P = 16;
   logic mclk, reset, psel, penable, pwrite, gie, rx_line, pready, pslverr, rx_ovr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   int n_fail, cmp_count;
   urx_receiver #(.BAUD_WIDTH(12)) i_dut (.mclk(mclk), .reset(reset), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .global_irq_enable(gie),
      .serial_rx_pin(rx_line), .rx_pin_override(rx_ovr), .rx_complete_irq(irq));
   urx_serial_src i_src (.mclk(mclk), .line(rx_line));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      check(rdat, {24'h0, e});
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr
   task automatic results;
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   initial begin
      repeat (60000) @(posedge mclk);
      n_fail++;
      results();
   end
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      gie = 1'b1;
      n_fail = 0;
      cmp_count = 0;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      rd(URX_FORMAT_OFS, URX_FORMAT_RST);
      wr(URX_CONTROL_OFS, 8'h10);
      rd(8'h14, 8'h00);
      i_src.send(9'h0a5, 8, -1, 1'b1, P);
      rd(URX_STATUS_OFS, 8'h80);
      rd(URX_DATA_OFS, 8'ha5);
      rd(URX_STATUS_OFS, 8'h00);
      i_src.send(9'h03c, 8, -1, 1'b0, P);
      wr(URX_STATUS_OFS, 8'h00);
      rd(URX_STATUS_OFS, 8'h90);
      rd(URX_DATA_OFS, 8'h3c);
      // Data 01 has odd weight, so even mode flags parity bit 0 and odd mode flags parity bit 1
      for (int i = 0; i < 4; i++) begin
         wr(URX_FORMAT_OFS, i[1] ? 8'h36 : 8'h26);
         i_src.send(9'h001, 8, i % 2, 1'b1, P);
         rd(URX_STATUS_OFS, {5'h10, i[0] == i[1], 2'h0});
         rd(URX_DATA_OFS, 8'h01);
      end
      wr(URX_FORMAT_OFS, 8'h06);
      i_src.send(9'h001, 8, -1, 1'b1, P);
      rd(URX_STATUS_OFS, 8'h80);
      rd(URX_DATA_OFS, 8'h01);
      wr(URX_FORMAT_OFS, 8'h00);
      i_src.send(9'h0ff, 5, -1, 1'b1, P);
      rd(URX_DATA_OFS, 8'h1f);
      wr(URX_FORMAT_OFS, 8'h0e);
      i_src.send(9'h1a5, 9, -1, 1'b1, P);
      rd(URX_CONTROL_OFS, 8'h12);
      rd(URX_DATA_OFS, 8'ha5);
      // Two stop bits selected; a 5-cycle spike must be rejected and a single-stop frame must still land
      wr(URX_FORMAT_OFS, 8'h46);
      i_src.spike(5);
      repeat (40) @(posedge mclk);
      rd(URX_STATUS_OFS, 8'h00);
      i_src.send(9'h05a, 8, -1, 1'b1, P);
      rd(URX_DATA_OFS, 8'h5a);
      wr(URX_STATUS_OFS, 8'h02);
      i_src.send(9'h0c3, 8, -1, 1'b1, 8);
      rd(URX_STATUS_OFS, 8'h82);
      rd(URX_DATA_OFS, 8'hc3);
      wr(URX_STATUS_OFS, 8'h00);
      // Two buffered; the held third is overwritten by the fourth, which is flagged
      for (int i = 0; i < 4; i++) i_src.send(9'(i + 16), 8, -1, 1'b1, P);
      rd(URX_STATUS_OFS, 8'h80);
      rd(URX_DATA_OFS, 8'h10);
      rd(URX_STATUS_OFS, 8'h80);
      rd(URX_DATA_OFS, 8'h11);
      rd(URX_STATUS_OFS, 8'h88);
      rd(URX_DATA_OFS, 8'h13);
      rd(URX_STATUS_OFS, 8'h00);
      i_src.send(9'h077, 8, -1, 1'b1, P);
      rd(URX_STATUS_OFS, 8'h80);
      rd(URX_DATA_OFS, 8'h77);
      wr(URX_CONTROL_OFS, 8'h90);
      i_src.send(9'h033, 8, -1, 1'b1, P);
      check({31'h0, irq}, 32'h1);
      gie <= 1'b0;
      @(posedge mclk);
      check({31'h0, irq}, 32'h0);
      gie <= 1'b1;
      rd(URX_DATA_OFS, 8'h33);
      @(posedge mclk);
      check({31'h0, irq}, 32'h0);
      i_src.send(9'h044, 8, -1, 1'b1, P);
      i_src.send(9'h055, 8, -1, 1'b1, P);
      wr(URX_CONTROL_OFS, 8'h00);
      @(posedge mclk);
      check({31'h0, rx_ovr}, 32'h0);
      rd(URX_STATUS_OFS, 8'h00);
      wr(URX_CONTROL_OFS, 8'h10);
      rd(URX_STATUS_OFS, 8'h00);
      check({31'h0, rx_ovr}, 32'h1);
      results();
   end
endmodule : tb_top
